/* rtl/rosc_pkg.sv */
// Operation
// - A masked flag still sets on its event but never drives the pin.
// - Reading the interrupt flag byte clears it.
// - Host may write flags to one to force interrupts.
// - Two 128-byte buffers, transmit at 0x200, receive at 0x300.
// - In init states only registers 0x00-0x07 and transmit preloads pass.
// - Leaving radio-off toward receive or transmit waits 50 us synth ramp.
// - Calibration runs after reset; a failure holds it and shows in status.
// - Reset pin release enters reset init; power-on flag is kept.
// - Power-up sets power-on flag, then unmaskable regulator-ready flag.
// - Deep sleep wake needs four data-in changes; regulator flag comes first.
// - Deep sleep wake: crystal settles, ready flag set, no recalibration.
// - After deep sleep return to listen if receive was on, else radio-off.
// - Sleep only from idle or radio-off via crystal-disable; preloads allowed.
// - Clearing crystal-disable ramps the crystal and returns to radio-off.
// - Deep sleep keeps register settings; only power loss or the reset pin drops them.
// - Receive-enable from off or idle enters listen; clearing goes idle.
// - Transmit-start sends; afterwards back to listen if receive on, else idle.
// - Idle waits off-timeout base units then radio-off; 0xff disables it.
// - Packet detect enters frame reception; end returns to listen, receive clear goes idle.
// - Power-save listen behaves as normal listen.
// - Latencies: off to listen 57 us, off to tx 52 us, idle to listen 6.8 us.
// - Deep sleep entry saves registers and shuts regulator, about 45 ms.
// - Pending indication is OR of enabled flags.
// - Interrupt pin is active low, gated by global interrupt enable.
package rosc_pkg;
  // ===========================================================
  // timing
  localparam int CLK_NS      = 8;
  localparam int SYNTH_NS    = 50000;
  localparam int OFF_RX_NS   = 57000;
  localparam int OFF_TX_NS   = 52000;
  localparam int IDLE_RX_NS  = 6800;
  localparam int IDLE_TX_NS  = 1300;
  localparam int XTAL_NS     = 1400000;
  localparam int DS_ENTRY_NS = 45000000;
  localparam int SYNTH_CYC   = (SYNTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFF_RX_CYC  = (OFF_RX_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFF_TX_CYC  = (OFF_TX_NS + CLK_NS - 1) / CLK_NS;
  localparam int IDLE_RX_CYC = (IDLE_RX_NS + CLK_NS - 1) / CLK_NS;
  localparam int IDLE_TX_CYC = (IDLE_TX_NS + CLK_NS - 1) / CLK_NS;
  localparam int XTAL_CYC    = (XTAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int DS_CYC      = (DS_ENTRY_NS + CLK_NS - 1) / CLK_NS;
  localparam int BASE_CYC    = 250;
  localparam int CNT_W       = 24;
  localparam logic [2:0] WAKE_EDGES = 3'h4;
  // ===========================================================
  // register map, word indices
  localparam logic [9:0] IDX_FLAGS    = 10'h000;
  localparam logic [9:0] IDX_MASK     = 10'h001;
  localparam logic [9:0] IDX_PIN      = 10'h002;
  localparam logic [9:0] IDX_STATUS   = 10'h003;
  localparam logic [9:0] IDX_INIT_MAX = 10'h007;
  localparam logic [9:0] IDX_CTRL     = 10'h010;
  localparam logic [9:0] IDX_OFF_TIMEOUT    = 10'h011;
  localparam logic [9:0] IDX_TXBUF    = 10'h200;
  localparam logic [9:0] IDX_RXBUF    = 10'h300;
  localparam int BUF_BYTES = 128;
  // ===========================================================
  // fields and reset values
  localparam int F_VREG = 0;
  localparam int F_RDY  = 1;
  localparam int F_TX   = 2;
  localparam int F_RX   = 3;
  localparam int P_GIE  = 6;
  localparam int P_IRQ  = 4;
  localparam int S_POR  = 0;
  localparam int S_CALF = 1;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [7:0] OFF_TIMEOUT_RST  = 8'hff;
  localparam logic [7:0] OFF_TIMEOUT_NONE = 8'hff;
  typedef enum logic [3:0] {
    ST_PIN_RST  = 4'h0, ST_INIT_RST = 4'h1, ST_INIT_DS = 4'h2,
    ST_CAL      = 4'h3, ST_OFF      = 4'h4, ST_IDLE    = 4'h5,
    ST_SLEEP    = 4'h6, ST_XTAL     = 4'h7, ST_DS_ENT  = 4'h8,
    ST_DEEP_SLEEP_REQUEST   = 4'h9, ST_RAMP     = 4'ha, ST_LISTEN  = 4'hb,
    ST_RX_FRAME = 4'hc, ST_TX_FRAME = 4'hd
  } rosc_state_t;
  typedef struct packed {
    logic [2:0] rsvd;
    logic       listen_power_save;
    logic       deep_sleep_request;
    logic       crystal_disable;
    logic       transmit_start;
    logic       receive_enable;
  } rosc_ctrl_t;
  localparam rosc_ctrl_t CTRL_RST = rosc_ctrl_t'(8'h00);
endpackage

/* rtl/rosc_top.sv */
`timescale 1ns/1ps
module rosc_top #(
  parameter int XTAL_CYC = rosc_pkg::XTAL_CYC,
  parameter int DS_CYC   = rosc_pkg::DS_CYC,
  parameter int OFFRX    = rosc_pkg::OFF_RX_CYC,
  parameter int OFFTX    = rosc_pkg::OFF_TX_CYC,
  parameter int SYNTH    = rosc_pkg::SYNTH_CYC,
  parameter int BASE_CYC = rosc_pkg::BASE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_pin_n,
  input  wire logic        sdi,
  input  wire logic        vreg_up,
  input  wire logic        cal_done,
  input  wire logic        cal_fail,
  input  wire logic        packet_detect,
  input  wire logic        rx_end,
  input  wire logic        tx_done,
  output logic             irq_n,
  output logic [3:0]       radio_state,
  output logic             listen_power_save
);
  // ===========================================================
  // declarations
  rosc_pkg::rosc_state_t   state_q;
  rosc_pkg::rosc_ctrl_t    ctrl_q;
  logic [rosc_pkg::CNT_W-1:0] cnt_q;
  logic [7:0]  flags_q, mask_q, off_timeout_q, to_cnt_q, set_ev, en;
  logic [15:0] base_q;
  logic        gie_q, por_q, calf_q, vwait_q, irq_q;
  logic        pin_s1, pin_s2, sdi_s1, sdi_s2, sdi_s3;
  logic [2:0]  edges_q;
  logic [7:0]  txbuf [rosc_pkg::BUF_BYTES];
  logic [7:0]  rxbuf [rosc_pkg::BUF_BYTES];
  logic [9:0]  idx;
  logic [6:0]  boff;
  logic        is_tx, is_rx, is_reg, ok, in_init, dead, acc_done;
  logic        wr, rd, pend, pin_rst, ds_done, cal_ok;
  logic [7:0]  rd_val, wb;
  rosc_pkg::rosc_ctrl_t    nc;

  assign radio_state       = state_q;
  assign irq_n             = irq_q;
  assign listen_power_save = ctrl_q.listen_power_save;
  // ===========================================================
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle level of the pin, so power-on reset gives no false pin reset
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      sdi_s3 <= 1'b0;
    end else begin
      pin_s1 <= reset_pin_n;
      pin_s2 <= pin_s1;
      sdi_s1 <= sdi;
      sdi_s2 <= sdi_s1;
      sdi_s3 <= sdi_s2;
    end
  end
  assign pin_rst = !pin_s2;
  // ===========================================================
  // apb decode
  always_comb begin
    idx     = paddr[11:2];
    boff    = idx[6:0];
    wb      = pwdata[7:0];
    is_tx   = idx[9:7] == rosc_pkg::IDX_TXBUF[9:7];
    is_rx   = idx[9:7] == rosc_pkg::IDX_RXBUF[9:7];
    in_init = state_q == rosc_pkg::ST_INIT_RST ||
              state_q == rosc_pkg::ST_INIT_DS;
    dead    = state_q == rosc_pkg::ST_PIN_RST ||
              state_q == rosc_pkg::ST_DEEP_SLEEP_REQUEST || state_q == rosc_pkg::ST_DS_ENT;
    is_reg  = 1'b1;
    rd_val  = 8'h00;
    unique case (idx)
      rosc_pkg::IDX_FLAGS:  rd_val = flags_q;
      rosc_pkg::IDX_MASK:   rd_val = mask_q;
      rosc_pkg::IDX_PIN: begin
        rd_val = 8'h00;
        rd_val[rosc_pkg::P_GIE] = gie_q;
        rd_val[rosc_pkg::P_IRQ] = pend;
      end
      rosc_pkg::IDX_STATUS: begin
        rd_val = {state_q, 4'h0};
        rd_val[rosc_pkg::S_POR]  = por_q;
        rd_val[rosc_pkg::S_CALF] = calf_q;
      end
      rosc_pkg::IDX_CTRL:   rd_val = ctrl_q;
      rosc_pkg::IDX_OFF_TIMEOUT:  rd_val = off_timeout_q;
      default: begin
        is_reg = 1'b0;
        if (is_tx) begin
          rd_val = txbuf[boff];
        end else if (is_rx) begin
          rd_val = rxbuf[boff];
        end
      end
    endcase
    // init: low registers and tx preloads only; sleep: no rx buffer
    ok = !dead && (is_reg ? (!in_init || idx <= rosc_pkg::IDX_INIT_MAX)
                          : is_tx || (is_rx && !in_init &&
                                      state_q != rosc_pkg::ST_SLEEP));
  end
  // ===========================================================
  // apb slave: two-cycle access, effects at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !ok;
      if (psel && penable && !pready && ok && !pwrite) begin
        prdata <= {24'h00_0000, rd_val};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
  assign acc_done = psel && penable && pready;
  assign wr       = acc_done && pwrite && !pslverr;
  assign rd       = acc_done && !pwrite && !pslverr;
  // buffers have no reset: contents survive sleep states
  always_ff @(posedge pclk) begin
    if (wr && is_tx) begin
      txbuf[boff] <= wb;
    end
    if (wr && is_rx) begin
      rxbuf[boff] <= wb;
    end
  end
  // ===========================================================
  // flags and interrupt
  assign cal_ok  = state_q == rosc_pkg::ST_CAL && cal_done && !cal_fail;
  assign ds_done = state_q == rosc_pkg::ST_INIT_DS && cnt_q == '0;
  always_comb begin
    set_ev = 8'h00;
    set_ev[rosc_pkg::F_VREG] = (vwait_q && vreg_up) ||
      (state_q == rosc_pkg::ST_DEEP_SLEEP_REQUEST && edges_q >= rosc_pkg::WAKE_EDGES);
    set_ev[rosc_pkg::F_RDY] = ds_done || cal_ok;
    set_ev[rosc_pkg::F_TX]  = state_q == rosc_pkg::ST_TX_FRAME && tx_done;
    set_ev[rosc_pkg::F_RX]  = state_q == rosc_pkg::ST_RX_FRAME && rx_end;
    en = mask_q;
    en[rosc_pkg::F_VREG] = 1'b1;
    pend = |(flags_q & en);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 8'h00;
      vwait_q <= 1'b1;
    end else begin
      if (vwait_q && vreg_up) begin
        vwait_q <= 1'b0;
      end
      if (pin_rst) begin
        flags_q <= 8'h00;
      end else begin
        // events win over the read clear; masked flags still set
        flags_q <= ((rd && idx == rosc_pkg::IDX_FLAGS) ? 8'h00 : flags_q)
                 | ((wr && idx == rosc_pkg::IDX_FLAGS) ? wb : 8'h00)
                 | set_ev;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b1;
    end else begin
      irq_q <= !(gie_q && pend);
    end
  end
  // ===========================================================
  // configuration registers
  always_comb begin
    nc = rosc_pkg::rosc_ctrl_t'(wb);
    nc.rsvd = 3'h0;
    // refuse transitions that have no valid path from here
    if (!(state_q inside {rosc_pkg::ST_OFF, rosc_pkg::ST_IDLE}) &&
        !(state_q == rosc_pkg::ST_SLEEP && !nc.crystal_disable)) begin
      nc.crystal_disable = ctrl_q.crystal_disable;
    end
    if (nc.deep_sleep_request && !(state_q inside {rosc_pkg::ST_OFF,
        rosc_pkg::ST_IDLE, rosc_pkg::ST_LISTEN})) begin
      nc.deep_sleep_request = ctrl_q.deep_sleep_request;
    end
    if (nc.transmit_start && !(state_q inside {rosc_pkg::ST_OFF,
        rosc_pkg::ST_IDLE, rosc_pkg::ST_LISTEN, rosc_pkg::ST_TX_FRAME,
        rosc_pkg::ST_RAMP})) begin
      nc.transmit_start = ctrl_q.transmit_start;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= rosc_pkg::CTRL_RST;
      mask_q  <= rosc_pkg::MASK_RST;
      off_timeout_q <= rosc_pkg::OFF_TIMEOUT_RST;
      gie_q   <= 1'b0;
      por_q   <= 1'b1;
    end else if (pin_rst) begin
      ctrl_q  <= rosc_pkg::CTRL_RST;
      mask_q  <= rosc_pkg::MASK_RST;
      off_timeout_q <= rosc_pkg::OFF_TIMEOUT_RST;
      gie_q   <= 1'b0;
    end else begin
      if (wr && idx == rosc_pkg::IDX_CTRL) begin
        ctrl_q <= nc;
      end else begin
        if (state_q == rosc_pkg::ST_TX_FRAME && tx_done) begin
          ctrl_q.transmit_start <= 1'b0;
        end
        if (ds_done) begin
          ctrl_q.deep_sleep_request <= 1'b0;
        end
      end
      if (wr && idx == rosc_pkg::IDX_MASK) begin
        mask_q <= wb;
      end
      if (wr && idx == rosc_pkg::IDX_OFF_TIMEOUT) begin
        off_timeout_q <= wb;
      end
      if (wr && idx == rosc_pkg::IDX_PIN) begin
        gie_q <= wb[rosc_pkg::P_GIE];
      end
      if (wr && idx == rosc_pkg::IDX_STATUS && wb[rosc_pkg::S_POR]) begin
        por_q <= 1'b0;
      end
    end
  end
  // ===========================================================
  // wake edge counter and idle off-timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edges_q  <= 3'h0;
      base_q   <= 16'h0000;
      to_cnt_q <= 8'h00;
    end else begin
      if (state_q != rosc_pkg::ST_DEEP_SLEEP_REQUEST) begin
        edges_q <= 3'h0;
      end else if (sdi_s2 != sdi_s3 && edges_q < rosc_pkg::WAKE_EDGES) begin
        edges_q <= edges_q + 3'h1;
      end
      if (state_q != rosc_pkg::ST_IDLE) begin
        base_q   <= 16'h0000;
        to_cnt_q <= 8'h00;
      end else if (base_q == 16'(BASE_CYC - 1)) begin
        base_q   <= 16'h0000;
        to_cnt_q <= to_cnt_q + 8'h01;
      end else begin
        base_q <= base_q + 16'h0001;
      end
    end
  end
  // ===========================================================
  // operating state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= rosc_pkg::ST_INIT_RST;
      cnt_q   <= rosc_pkg::CNT_W'(XTAL_CYC);
      calf_q  <= 1'b0;
    end else if (pin_rst) begin
      state_q <= rosc_pkg::ST_PIN_RST;
      calf_q  <= 1'b0;
    end else begin
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
      unique case (state_q)
        rosc_pkg::ST_PIN_RST: begin
          state_q <= rosc_pkg::ST_INIT_RST;
          cnt_q   <= rosc_pkg::CNT_W'(XTAL_CYC);
        end
        rosc_pkg::ST_INIT_RST: begin
          if (cnt_q == '0) begin
            state_q <= rosc_pkg::ST_CAL;
          end
        end
        rosc_pkg::ST_CAL: begin
          if (cal_fail) begin
            calf_q <= 1'b1;
          end else if (cal_done) begin
            state_q <= rosc_pkg::ST_OFF;
          end
        end
        rosc_pkg::ST_OFF, rosc_pkg::ST_IDLE: begin
          if (ctrl_q.deep_sleep_request) begin
            state_q <= rosc_pkg::ST_DS_ENT;
            cnt_q   <= rosc_pkg::CNT_W'(DS_CYC);
          end else if (ctrl_q.crystal_disable) begin
            state_q <= rosc_pkg::ST_SLEEP;
          end else if (ctrl_q.transmit_start) begin
            state_q <= rosc_pkg::ST_RAMP;
            cnt_q   <= (state_q == rosc_pkg::ST_OFF) ?
                       rosc_pkg::CNT_W'(OFFTX) :
                       rosc_pkg::CNT_W'(rosc_pkg::IDLE_TX_CYC);
          end else if (ctrl_q.receive_enable) begin
            state_q <= rosc_pkg::ST_RAMP;
            cnt_q   <= (state_q == rosc_pkg::ST_OFF) ?
                       rosc_pkg::CNT_W'(OFFRX) :
                       rosc_pkg::CNT_W'(rosc_pkg::IDLE_RX_CYC);
          end else if (state_q == rosc_pkg::ST_IDLE &&
                       off_timeout_q != rosc_pkg::OFF_TIMEOUT_NONE &&
                       to_cnt_q >= off_timeout_q) begin
            state_q <= rosc_pkg::ST_OFF;
          end
        end
        rosc_pkg::ST_SLEEP: begin
          if (!ctrl_q.crystal_disable) begin
            state_q <= rosc_pkg::ST_XTAL;
            cnt_q   <= rosc_pkg::CNT_W'(XTAL_CYC);
          end
        end
        rosc_pkg::ST_XTAL: begin
          if (cnt_q == '0) begin
            state_q <= rosc_pkg::ST_OFF;
          end
        end
        rosc_pkg::ST_DS_ENT: begin
          if (cnt_q == '0) begin
            state_q <= rosc_pkg::ST_DEEP_SLEEP_REQUEST;
          end
        end
        rosc_pkg::ST_DEEP_SLEEP_REQUEST: begin
          if (edges_q >= rosc_pkg::WAKE_EDGES) begin
            state_q <= rosc_pkg::ST_INIT_DS;
            cnt_q   <= rosc_pkg::CNT_W'(XTAL_CYC);
          end
        end
        rosc_pkg::ST_INIT_DS: begin
          // stored settings kept, so calibration is skipped
          if (cnt_q == '0) begin
            state_q <= ctrl_q.receive_enable ? rosc_pkg::ST_RAMP
                                             : rosc_pkg::ST_OFF;
            cnt_q   <= rosc_pkg::CNT_W'(OFFRX);
          end
        end
        rosc_pkg::ST_RAMP: begin
          if (cnt_q == '0) begin
            state_q <= ctrl_q.transmit_start ? rosc_pkg::ST_TX_FRAME
                                             : rosc_pkg::ST_LISTEN;
          end
        end
        rosc_pkg::ST_LISTEN: begin
          if (ctrl_q.transmit_start) begin
            state_q <= rosc_pkg::ST_TX_FRAME;
          end else if (!ctrl_q.receive_enable) begin
            state_q <= rosc_pkg::ST_IDLE;
          end else if (ctrl_q.deep_sleep_request) begin
            state_q <= rosc_pkg::ST_DS_ENT;
            cnt_q   <= rosc_pkg::CNT_W'(DS_CYC);
          end else if (packet_detect) begin
            state_q <= rosc_pkg::ST_RX_FRAME;
          end
        end
        rosc_pkg::ST_RX_FRAME: begin
          if (!ctrl_q.receive_enable) begin
            state_q <= rosc_pkg::ST_IDLE;
          end else if (rx_end) begin
            state_q <= rosc_pkg::ST_LISTEN;
          end
        end
        rosc_pkg::ST_TX_FRAME: begin
          if (tx_done || !ctrl_q.transmit_start) begin
            state_q <= ctrl_q.receive_enable ? rosc_pkg::ST_LISTEN
                                             : rosc_pkg::ST_IDLE;
          end
        end
        default: state_q <= rosc_pkg::ST_OFF;
      endcase
    end
  end
  // ===========================================================
  // checks
  logic [rosc_pkg::CNT_W-1:0] ramp_age_q;
  logic                       ramp_off_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_age_q <= '0;
      ramp_off_q <= 1'b0;
    end else begin
      ramp_age_q <= (state_q == rosc_pkg::ST_RAMP) ? ramp_age_q + 1'b1 : '0;
      if (state_q != rosc_pkg::ST_RAMP) begin
        ramp_off_q <= state_q == rosc_pkg::ST_OFF;
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ramp_synth_wait: assert property (
    state_q == rosc_pkg::ST_RAMP && ramp_off_q
    ##1 state_q != rosc_pkg::ST_RAMP |-> $past(ramp_age_q) >= SYNTH)
    else $error("synth ramp cut short");
  a_masked_no_irq: assert property (
    flags_q == 8'h08 && mask_q == 8'h00 |=> irq_n)
    else $error("masked flag drove the pin");
  a_flag_read_clear: assert property (
    rd && idx == rosc_pkg::IDX_FLAGS && set_ev == 8'h00 |=> flags_q == 8'h00)
    else $error("flag byte not cleared by read");
  a_flag_force_set: assert property (
    wr && idx == rosc_pkg::IDX_FLAGS |=> (flags_q & $past(wb)) == $past(wb))
    else $error("forced flag not set");
  a_init_refuse: assert property (
    psel && penable && !pready && in_init && is_reg &&
    idx > rosc_pkg::IDX_INIT_MAX |=> pslverr && pready)
    else $error("init access not refused");
  a_cal_fail_hold: assert property (
    state_q == rosc_pkg::ST_CAL && cal_fail && !pin_rst |=>
    state_q == rosc_pkg::ST_CAL ##0 calf_q)
    else $error("calibration failure left state");
  a_vreg_unmasked: assert property (
    flags_q[rosc_pkg::F_VREG] && gie_q |=> !irq_n)
    else $error("regulator flag masked");
  a_wake_vreg: assert property (
    state_q == rosc_pkg::ST_DEEP_SLEEP_REQUEST ##1 state_q == rosc_pkg::ST_INIT_DS
    |-> flags_q[rosc_pkg::F_VREG] && $past(edges_q) == rosc_pkg::WAKE_EDGES)
    else $error("wake without four edges or regulator flag");
  a_rx_clear_idle: assert property (
    state_q == rosc_pkg::ST_LISTEN && !ctrl_q.receive_enable &&
    !ctrl_q.transmit_start && !pin_rst |=> state_q == rosc_pkg::ST_IDLE)
    else $error("listen did not drop to idle");
  a_off_timeout_none: assert property (
    state_q == rosc_pkg::ST_IDLE && off_timeout_q == rosc_pkg::OFF_TIMEOUT_NONE &&
    ctrl_q == rosc_pkg::CTRL_RST && !pin_rst |=> state_q == rosc_pkg::ST_IDLE)
    else $error("idle left with timeout disabled");
  a_irq_gie_gate: assert property (
    !gie_q [*2] |-> irq_n)
    else $error("pin active without global enable");
  c_tx_frame: cover property (
    state_q == rosc_pkg::ST_TX_FRAME ##1 state_q == rosc_pkg::ST_LISTEN);
  c_rx_frame: cover property (
    state_q == rosc_pkg::ST_RX_FRAME ##1 state_q == rosc_pkg::ST_LISTEN);
  c_ds_wake: cover property (
    state_q == rosc_pkg::ST_INIT_DS ##1 state_q != rosc_pkg::ST_INIT_DS);
  c_sleep_exit: cover property (
    state_q == rosc_pkg::ST_XTAL ##1 state_q == rosc_pkg::ST_OFF);
endmodule

/* dv/rosc_radio_model.sv */
`timescale 1ns/1ps
// ========================================
// radio front end stand-in
module rosc_radio_model (
  input  wire logic       pclk,
  input  wire logic [3:0] st,
  output logic            cal_done,
  output logic            rx_end,
  output logic            tx_done
);
  logic [3:0] prev_q;
  logic [3:0] age_q;
  // results come some cycles late, or at state entry if the wrapped age_q left by the last state matches
  always_ff @(posedge pclk) begin
    prev_q <= st;
    age_q  <= (st != prev_q) ? 4'h0 : age_q + 4'h1;
  end
  assign cal_done = (st == rosc_pkg::ST_CAL) && (age_q == 4'h3);
  assign rx_end   = (st == rosc_pkg::ST_RX_FRAME) && (age_q == 4'h6);
  assign tx_done  = (st == rosc_pkg::ST_TX_FRAME) && (age_q == 4'h5);
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
// ========================================
// bench
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, sdi, pkt, pin_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq_n, lps, cd, re, td, e, vup, cfl;
  logic [3:0]  st;
  logic [7:0]  q;
  int          n_fail, checked, cyc;
  rosc_top #(.XTAL_CYC(20), .DS_CYC(30), .OFFRX(12), .OFFTX(10), .SYNTH(8))
    dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(pin_n), .sdi(sdi), .vreg_up(vup), .cal_done(cd),
    .cal_fail(cfl), .packet_detect(pkt), .rx_end(re), .tx_done(td),
    .irq_n(irq_n), .radio_state(st), .listen_power_save(lps));
  rosc_radio_model model (.pclk(pclk), .st(st), .cal_done(cd),
    .rx_end(re), .tx_done(td));
  task automatic summarize();
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {ix, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] ix, input logic [7:0] x, input logic xe);
    apb(1'b0, ix, 8'h00);
    chk(q, x);
    chk({7'h0, e}, {7'h0, xe});
  endtask
  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d);
    chk({7'h0, e}, 8'h00);
  endtask
  // bounded wait, a stuck state shows as a mismatch
  task automatic wst(input logic [3:0] s);
    for (int i = 0; i < 3000 && st !== s; i++) @(posedge pclk);
    chk({4'h0, st}, {4'h0, s});
  endtask
  task automatic t_init();
    rd(10'h011, 8'h00, 1'b1);
    rd(10'h000, 8'h00, 1'b0);
    vup <= 1'b1;
    rd(10'h001, 8'h00, 1'b0);
    wst(rosc_pkg::ST_OFF);
    rd(10'h011, 8'hff, 1'b0);
    rd(10'h003, 8'h41, 1'b0);
    rd(10'h000, 8'h03, 1'b0);
    rd(10'h000, 8'h00, 1'b0);
  endtask
  task automatic t_rx();
    wr(10'h010, 8'h11);
    wst(rosc_pkg::ST_LISTEN);
    chk({7'h0, lps}, 8'h01);
    pkt <= 1'b1;
    wst(rosc_pkg::ST_RX_FRAME);
    pkt <= 1'b0;
    wst(rosc_pkg::ST_LISTEN);
    wr(10'h010, 8'h00);
    wst(rosc_pkg::ST_IDLE);
  endtask
  task automatic t_tx();
    wr(10'h010, 8'h02);
    wst(rosc_pkg::ST_TX_FRAME);
    wst(rosc_pkg::ST_IDLE);
    rd(10'h010, 8'h00, 1'b0);
    rd(10'h000, 8'h0c, 1'b0);
  endtask
  task automatic t_irq();
    wr(10'h002, 8'h40);
    wr(10'h000, 8'h01);
    repeat (3) @(posedge pclk);
    chk({7'h0, irq_n}, 8'h00);
    rd(10'h000, 8'h01, 1'b0);
    wr(10'h000, 8'h08);
    repeat (3) @(posedge pclk);
    chk({7'h0, irq_n}, 8'h01);
    wr(10'h001, 8'h08);
    repeat (3) @(posedge pclk);
    chk({7'h0, irq_n}, 8'h00);
    rd(10'h002, 8'h50, 1'b0);
    wr(10'h002, 8'h00);
    repeat (3) @(posedge pclk);
    chk({7'h0, irq_n}, 8'h01);
    rd(10'h000, 8'h08, 1'b0);
  endtask
  task automatic t_tmo();
    wr(10'h011, 8'h02);
    wr(10'h010, 8'h01);
    wst(rosc_pkg::ST_LISTEN);
    wr(10'h010, 8'h00);
    wst(rosc_pkg::ST_IDLE);
    wst(rosc_pkg::ST_OFF);
  endtask
  task automatic t_sleep();
    wr(10'h010, 8'h04);
    wst(rosc_pkg::ST_SLEEP);
    wr(10'h27f, 8'h5a);
    rd(10'h300, 8'h00, 1'b1);
    wr(10'h010, 8'h00);
    wst(rosc_pkg::ST_OFF);
    rd(10'h27f, 8'h5a, 1'b0);
  endtask
  task automatic t_ds();
    wr(10'h003, 8'h01);
    apb(1'b0, 10'h000, 8'h00);
    wr(10'h010, 8'h08);
    wst(rosc_pkg::ST_DEEP_SLEEP_REQUEST);
    rd(10'h003, 8'h00, 1'b1);
    // serial link edges at 80 ns, slower than the bus clock
    repeat (4) begin
      repeat (10) @(posedge pclk);
      sdi <= ~sdi;
    end
    wst(rosc_pkg::ST_OFF);
    rd(10'h000, 8'h03, 1'b0);
    rd(10'h003, 8'h40, 1'b0);
    rd(10'h011, 8'h02, 1'b0);
  endtask
  task automatic t_pin();
    pin_n <= 1'b0;
    wst(rosc_pkg::ST_PIN_RST);
    pin_n <= 1'b1;
    cfl   <= 1'b1;
    wst(rosc_pkg::ST_CAL);
    repeat (20) @(posedge pclk);
    chk({4'h0, st}, {4'h0, rosc_pkg::ST_CAL});
    rd(10'h003, 8'h32, 1'b0);
    cfl <= 1'b0;
    wst(rosc_pkg::ST_OFF);
    rd(10'h003, 8'h42, 1'b0);
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, sdi, pkt} = 6'h0;
    pin_n  = 1'b1;
    vup    = 1'b0;
    cfl    = 1'b0;
    paddr  = 12'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_init();
    t_rx();
    t_tx();
    t_irq();
    t_tmo();
    t_sleep();
    t_ds();
    t_pin();
    summarize();
  end
endmodule
